// ---- src/spindle_gear_ctrl.v ----
// analog spindle speed and gear controller: scales speed commands to 12-bit
// motor codes for two spindles, picks or follows gears, runs the strobe handshake.
// assumes synchronous plc inputs and a single-cycle-ish avalon-mm master.
`timescale 1ns/1ns
`default_nettype none
`include "spindle_gear_regs.vh"

module spindle_gear_ctrl (
    // clock and reset
    input  wire        CORE_CLK,
    input  wire        RST_N,
    // avalon-mm slave
    input  wire [5:0]  AVS_ADDRESS,
    input  wire        AVS_READ,
    input  wire        AVS_WRITE,
    input  wire [31:0] AVS_WRITEDATA,
    output reg  [31:0] AVS_READDATA,
    output wire        AVS_WAITREQUEST,
    // plc inputs
    input  wire        FIRST_SPINDLE_SELECT,
    input  wire        SECOND_SPINDLE_SELECT,
    input  wire        GEAR_CODE_BIT_LOW,
    input  wire        GEAR_CODE_BIT_HIGH,
    input  wire        SECOND_GEAR_CODE_BIT_LOW,
    input  wire        SECOND_GEAR_CODE_BIT_HIGH,
    input  wire        PLC_SPEED_SOURCE_FIRST,
    input  wire        PLC_SPEED_SOURCE_SECOND,
    input  wire [11:0] PLC_SPEED_CODE_INPUT,
    input  wire [11:0] PLC_SPEED_CODE_INPUT_SECOND,
    input  wire        PLC_COMPLETION,
    // plc outputs
    output reg  [11:0] COMPUTED_SPEED_CODE_OUTPUT,
    output reg  [11:0] COMPUTED_SPEED_CODE_OUTPUT_SECOND,
    output reg  [15:0] SPEED_COMMAND_BINARY,
    output reg         AUTO_GEAR_ONE_FLAG,
    output reg         AUTO_GEAR_TWO_FLAG,
    output reg         AUTO_GEAR_THREE_FLAG,
    output reg         AUTO_GEAR_FOUR_FLAG,
    output reg         SPEED_STROBE,
    // compensated codes toward the converter
    output reg  [11:0] ANALOG_SPEED_VOLTAGE,
    output reg  [11:0] ANALOG_SPEED_VOLTAGE_SECOND,
    // block done, next program block may proceed
    output reg         BLOCK_DONE
);

    localparam [2:0] S_IDLE  = 3'd0;
    localparam [2:0] S_CALC  = 3'd1;
    localparam [2:0] S_DLY1  = 3'd2;
    localparam [2:0] S_STRB  = 3'd3;
    localparam [2:0] S_DLY2  = 3'd4;
    localparam [2:0] S_FIN   = 3'd5;
    localparam [2:0] S_OUT   = 3'd6;

    // cycles per delay unit: 1 ms at the core rate
    localparam [31:0] UNIT_CYC = `TMF_UNIT_MS * `CLK_MHZ * 1000;

    // ****************************************
    // registers
    // ****************************************
    reg  [2:0]  ctrl_q;
    reg  [13:0] cmd_q;
    reg  [13:0] gmax1_q [0:3];
    reg  [13:0] gmax2_q [0:3];
    reg  [11:0] vmin_q;
    reg  [11:0] vmax_q;
    reg  [11:0] sw_q [0:2];
    reg  [13:0] ofs_hi_q;
    reg  [13:0] ofs_lo_q;
    reg  [15:0] tmf_q;
    reg  [2:0]  st_q;
    reg  [1:0]  agear_q;
    reg  [15:0] tmf_cnt_q;
    reg  [31:0] unit_cnt_q;
    reg  [11:0] code1_q;
    reg  [11:0] code2_q;
    reg  [11:0] code1_new_q;
    reg         sel1_q;
    reg         sel2_q;
    reg         pend_q;

    wire        auto_en = ctrl_q[`C_AUTO] & ~ctrl_q[`C_DUAL];
    wire [1:0]  gcode1  = {GEAR_CODE_BIT_HIGH, GEAR_CODE_BIT_LOW};
    wire [1:0]  gcode2  = {SECOND_GEAR_CODE_BIT_HIGH, SECOND_GEAR_CODE_BIT_LOW};
    wire        wr      = AVS_WRITE;
    wire [1:0]  gsel    = AVS_ADDRESS[1:0] - 2'd1;

    // slave answers in the request cycle
    assign AVS_WAITREQUEST = 1'b0;

    // ****************************************
    // functions
    // ****************************************
    // speed / gear max * 4095, saturated at full scale
    function [11:0] scale;
        input [13:0] spd;
        input [13:0] gmax;
        reg   [25:0] p;
        reg   [25:0] q;
        begin
            p = {12'h000, spd} * 26'd4095;
            q = 26'h0000000;
            if (gmax == 14'h0000 || spd >= gmax) begin
                scale = `FULL_CODE;
            end else begin
                q     = p / {12'h000, gmax};
                scale = q[11:0];
            end
        end
    endfunction

    // (9999 + hi - lo)/9999 * code + lo*4095/9999, clamped to 12 bits
    function [11:0] comp;
        input [11:0] code;
        input [13:0] hi;
        input [13:0] lo;
        reg   [31:0] gain;
        reg   [31:0] acc;
        begin
            gain = {18'h00000, `OFS_BASE} + {18'h00000, hi} - {18'h00000, lo};
            acc  = (gain * {20'h00000, code} + {18'h00000, lo} * 32'd4095) / {18'h00000, `OFS_BASE};
            if (gain[31]) begin
                comp = 12'h000;
            end else if (acc > 32'd4095) begin
                comp = `FULL_CODE;
            end else begin
                comp = acc[11:0];
            end
        end
    endfunction

    function [11:0] clampv;
        input [11:0] v;
        input [11:0] lo;
        input [11:0] hi;
        begin
            clampv = (v < lo) ? lo : ((v > hi) ? hi : v);
        end
    endfunction

    // ****************************************
    // gear choice for auto mode
    // ****************************************
    reg [1:0]  pick;
    reg [11:0] raw;
    integer    i;
    integer    j;
    always @* begin
        pick = 2'd3;
        raw  = 12'h000;
        for (i = 3; i >= 0; i = i - 1) begin
            raw = scale(cmd_q, gmax1_q[i]);
            if (ctrl_q[`C_VARB]) begin
                // variant B: leave gear at its switching code
                if (i == 3 || raw <= sw_q[i]) begin
                    pick = i[1:0];
                end
            end else begin
                // variant A: lowest gear that stays within motor max
                if (gmax1_q[i] != 14'h0000 && cmd_q <= gmax1_q[i] && raw <= vmax_q) begin
                    pick = i[1:0];
                end
            end
        end
    end
    wire [11:0] auto_code = clampv(scale(cmd_q, gmax1_q[pick]), vmin_q, vmax_q);
    wire [11:0] ext1_code = scale(cmd_q, gmax1_q[gcode1]);
    wire [11:0] ext2_code = scale(cmd_q, gmax2_q[gcode2]);

    // ****************************************
    // bus and sequencing
    // ****************************************
    always @(posedge CORE_CLK) begin
        if (!RST_N) begin
            ctrl_q      <= 3'b000;
            cmd_q       <= 14'h0000;
            for (j = 0; j < 4; j = j + 1) begin
                gmax1_q[j] <= `GMAX_RST;
                gmax2_q[j] <= `GMAX_RST;
            end
            for (j = 0; j < 3; j = j + 1) begin
                sw_q[j] <= `VMAX_RST;
            end
            vmin_q      <= `VMIN_RST;
            vmax_q      <= `VMAX_RST;
            ofs_hi_q    <= 14'h0000;
            ofs_lo_q    <= 14'h0000;
            tmf_q       <= `TMF_RST;
            st_q        <= S_IDLE;
            agear_q     <= 2'd0;
            tmf_cnt_q   <= 16'h0000;
            unit_cnt_q  <= 32'h00000000;
            code1_q     <= 12'h000;
            code2_q     <= 12'h000;
            code1_new_q <= 12'h000;
            sel1_q      <= 1'b0;
            sel2_q      <= 1'b0;
            pend_q      <= 1'b0;
            SPEED_STROBE <= 1'b0;
            SPEED_COMMAND_BINARY <= 16'h0000;
            BLOCK_DONE  <= 1'b0;
        end else begin
            BLOCK_DONE <= 1'b0;
            if (wr) begin
                case (AVS_ADDRESS)
                    `A_CTRL:   ctrl_q   <= AVS_WRITEDATA[2:0];
                    `A_CMD: begin
                        cmd_q  <= AVS_WRITEDATA[13:0];
                        pend_q <= 1'b1;
                    end
                    `A_VMIN:   vmin_q   <= AVS_WRITEDATA[11:0];
                    `A_VMAX:   vmax_q   <= AVS_WRITEDATA[11:0];
                    `A_OFS_HI: ofs_hi_q <= AVS_WRITEDATA[13:0];
                    `A_OFS_LO: ofs_lo_q <= AVS_WRITEDATA[13:0];
                    `A_TMF:    tmf_q    <= AVS_WRITEDATA[15:0];
                    `A_BCD: begin
                    end
                    default: begin
                        if (AVS_ADDRESS >= `A_GMAX1 && AVS_ADDRESS < `A_GMAX2) begin
                            gmax1_q[AVS_ADDRESS[1:0] - 2'd1] <= AVS_WRITEDATA[13:0];
                        end else if (AVS_ADDRESS >= `A_GMAX2 && AVS_ADDRESS < `A_VMIN) begin
                            gmax2_q[gsel] <= AVS_WRITEDATA[13:0];
                        end else if (AVS_ADDRESS >= `A_SW1 && AVS_ADDRESS < `A_OFS_HI) begin
                            sw_q[AVS_ADDRESS[1:0] - 2'd3] <= AVS_WRITEDATA[11:0];
                        end
                    end
                endcase
            end
            case (st_q)
                S_IDLE: begin
                    if (pend_q) begin
                        // a command written in this very cycle stays pending
                        if (!(wr && AVS_ADDRESS == `A_CMD)) begin
                            pend_q <= 1'b0;
                        end
                        sel1_q <= FIRST_SPINDLE_SELECT;
                        sel2_q <= SECOND_SPINDLE_SELECT;
                        SPEED_COMMAND_BINARY <= {2'b00, cmd_q};
                        st_q   <= S_CALC;
                    end
                end
                S_CALC: begin
                    if (cmd_q == 14'h0000) begin
                        // zero command clears both spindles regardless of select
                        code1_q <= 12'h000;
                        code2_q <= 12'h000;
                        st_q    <= S_OUT;
                    end else if (auto_en) begin
                        code1_new_q <= auto_code;
                        if (pick != agear_q) begin
                            agear_q     <= pick;
                            tmf_cnt_q   <= 16'h0000;
                            unit_cnt_q  <= 32'h00000000;
                            st_q        <= S_DLY1;
                        end else begin
                            code1_q <= auto_code;
                            st_q    <= S_OUT;
                        end
                    end else begin
                        // unselected spindle holds its old code
                        if (sel1_q) begin
                            code1_q <= ext1_code;
                        end
                        if (sel2_q) begin
                            code2_q <= ext2_code;
                        end
                        st_q <= S_OUT;
                    end
                end
                S_DLY1, S_DLY2: begin
                    if (unit_cnt_q == UNIT_CYC - 32'd1) begin
                        unit_cnt_q <= 32'h00000000;
                        tmf_cnt_q  <= tmf_cnt_q + 16'd1;
                    end else begin
                        unit_cnt_q <= unit_cnt_q + 32'd1;
                    end
                    if (tmf_cnt_q >= tmf_q) begin
                        tmf_cnt_q  <= 16'h0000;
                        unit_cnt_q <= 32'h00000000;
                        if (st_q == S_DLY1) begin
                            SPEED_STROBE <= 1'b1;
                            st_q <= S_DLY2;
                        end else begin
                            code1_q <= code1_new_q;
                            st_q    <= S_FIN;
                        end
                    end
                end
                S_FIN: begin
                    if (PLC_COMPLETION) begin
                        SPEED_STROBE <= 1'b0;
                        st_q <= S_OUT;
                    end
                end
                S_OUT: begin
                    BLOCK_DONE <= 1'b1;
                    st_q <= S_IDLE;
                end
                default: st_q <= S_IDLE;
            endcase
        end
    end

    // ****************************************
    // output stage
    // ****************************************
    // plc source substitutes per spindle; first input never reaches second
    wire [11:0] fin1 = PLC_SPEED_SOURCE_FIRST  ? PLC_SPEED_CODE_INPUT        : code1_q;
    wire [11:0] fin2 = PLC_SPEED_SOURCE_SECOND ? PLC_SPEED_CODE_INPUT_SECOND : code2_q;

    always @(posedge CORE_CLK) begin
        if (!RST_N) begin
            COMPUTED_SPEED_CODE_OUTPUT        <= 12'h000;
            COMPUTED_SPEED_CODE_OUTPUT_SECOND <= 12'h000;
            ANALOG_SPEED_VOLTAGE              <= 12'h000;
            ANALOG_SPEED_VOLTAGE_SECOND       <= 12'h000;
            AUTO_GEAR_ONE_FLAG   <= 1'b0;
            AUTO_GEAR_TWO_FLAG   <= 1'b0;
            AUTO_GEAR_THREE_FLAG <= 1'b0;
            AUTO_GEAR_FOUR_FLAG  <= 1'b0;
        end else begin
            COMPUTED_SPEED_CODE_OUTPUT        <= fin1;
            COMPUTED_SPEED_CODE_OUTPUT_SECOND <= fin2;
            ANALOG_SPEED_VOLTAGE              <= comp(fin1, ofs_hi_q, ofs_lo_q);
            ANALOG_SPEED_VOLTAGE_SECOND       <= comp(fin2, ofs_hi_q, ofs_lo_q);
            AUTO_GEAR_ONE_FLAG   <= auto_en & (agear_q == 2'd0);
            AUTO_GEAR_TWO_FLAG   <= auto_en & (agear_q == 2'd1);
            AUTO_GEAR_THREE_FLAG <= auto_en & (agear_q == 2'd2);
            AUTO_GEAR_FOUR_FLAG  <= auto_en & (agear_q == 2'd3);
        end
    end

    // ****************************************
    // read mux
    // ****************************************
    always @* begin
        AVS_READDATA = 32'h00000000;
        case (AVS_ADDRESS)
            `A_CTRL:   AVS_READDATA = {29'h0, ctrl_q};
            `A_CMD:    AVS_READDATA = {18'h0, cmd_q};
            `A_STAT:   AVS_READDATA = {24'h0, pend_q, st_q, SPEED_STROBE, auto_en, agear_q};
            `A_CODE1:  AVS_READDATA = {20'h0, COMPUTED_SPEED_CODE_OUTPUT};
            `A_CODE2:  AVS_READDATA = {20'h0, COMPUTED_SPEED_CODE_OUTPUT_SECOND};
            `A_VMIN:   AVS_READDATA = {20'h0, vmin_q};
            `A_VMAX:   AVS_READDATA = {20'h0, vmax_q};
            `A_OFS_HI: AVS_READDATA = {18'h0, ofs_hi_q};
            `A_OFS_LO: AVS_READDATA = {18'h0, ofs_lo_q};
            `A_TMF:    AVS_READDATA = {16'h0, tmf_q};
            default: begin
                if (AVS_ADDRESS >= `A_GMAX1 && AVS_ADDRESS < `A_GMAX2) begin
                    AVS_READDATA = {18'h0, gmax1_q[AVS_ADDRESS[1:0] - 2'd1]};
                end else if (AVS_ADDRESS >= `A_GMAX2 && AVS_ADDRESS < `A_VMIN) begin
                    AVS_READDATA = {18'h0, gmax2_q[gsel]};
                end else if (AVS_ADDRESS >= `A_SW1 && AVS_ADDRESS < `A_OFS_HI) begin
                    AVS_READDATA = {20'h0, sw_q[AVS_ADDRESS[1:0] - 2'd3]};
                end
            end
        endcase
        // reads outside a request return zero
        if (!AVS_READ) begin
            AVS_READDATA = 32'h00000000;
        end
    end

endmodule
`default_nettype wire

// ---- src/spindle_gear_regs.vh ----
// constants for the analog spindle speed and gear controller
// assumes a 125 MHz core clock and 32-bit avalon-mm register access
`ifndef SPINDLE_GEAR_REGS_VH
`define SPINDLE_GEAR_REGS_VH

// ****************************************
// register word addresses
// ****************************************
`define A_CTRL        6'h00
`define A_CMD         6'h01
`define A_STAT        6'h02
`define A_CODE1       6'h03
`define A_CODE2       6'h04
`define A_GMAX1       6'h05
`define A_GMAX2       6'h09
`define A_VMIN        6'h0D
`define A_VMAX        6'h0E
`define A_SW1         6'h0F
`define A_OFS_HI      6'h12
`define A_OFS_LO      6'h13
`define A_TMF         6'h14
`define A_BCD         6'h15

// ****************************************
// control register fields
// ****************************************
`define C_AUTO        0
`define C_VARB        1
`define C_DUAL        2

// ****************************************
// scaling constants and reset values
// ****************************************
`define FULL_CODE     12'hFFF
`define OFS_BASE      14'h270F
`define GMAX_RST      14'h270F
`define VMAX_RST      12'hFFF
`define VMIN_RST      12'h000
`define TMF_RST       16'h0010
`define CLK_MHZ       125
`define TMF_UNIT_MS   1

`endif

// ---- test/spindle_gear_checker.sv ----
// assertion checker for the spindle speed and gear controller
// assumes it is bound to the controller top and sees only its ports
`timescale 1ns/1ns
`default_nettype none
module spindle_gear_checker (
    // clock and reset
    input wire logic        CORE_CLK,
    input wire logic        RST_N,
    // register bus
    input wire logic [5:0]  AVS_ADDRESS,
    input wire logic        AVS_READ,
    input wire logic [31:0] AVS_READDATA,
    input wire logic        AVS_WAITREQUEST,
    // plc handshake and gear flags
    input wire logic        PLC_COMPLETION,
    input wire logic        SPEED_STROBE,
    input wire logic        AUTO_GEAR_ONE_FLAG,
    input wire logic        AUTO_GEAR_TWO_FLAG,
    input wire logic        AUTO_GEAR_THREE_FLAG,
    input wire logic        AUTO_GEAR_FOUR_FLAG,
    input wire logic        BLOCK_DONE
);
    wire [3:0] flags = {AUTO_GEAR_FOUR_FLAG, AUTO_GEAR_THREE_FLAG, AUTO_GEAR_TWO_FLAG, AUTO_GEAR_ONE_FLAG};

    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!RST_N);

    a_bus_no_wait: assert property (!AVS_WAITREQUEST)
        else $error("waitrequest raised");
    a_unmapped_zero: assert property (AVS_READ && AVS_ADDRESS >= 6'h20 |-> AVS_READDATA == 32'h0)
        else $error("unmapped read not zero");
    a_flags_onehot: assert property ($onehot0(flags))
        else $error("gear flags not one-hot");
    a_strobe_gear: assert property (SPEED_STROBE |-> flags != 4'h0)
        else $error("strobe without an automatic gear");
    a_strobe_hold: assert property (SPEED_STROBE && !PLC_COMPLETION |=> SPEED_STROBE)
        else $error("strobe dropped before completion");
    a_strobe_drop: assert property (SPEED_STROBE && PLC_COMPLETION |-> ##[1:2] !SPEED_STROBE)
        else $error("strobe stayed after completion");
    a_flags_frozen: assert property (SPEED_STROBE |=> $stable(flags))
        else $error("gear flags moved during strobe");
    a_done_pulse: assert property (BLOCK_DONE |=> !BLOCK_DONE)
        else $error("done longer than one cycle");
    a_done_quiet: assert property (BLOCK_DONE |-> !SPEED_STROBE)
        else $error("done while strobe high");
endmodule
`default_nettype wire

// ---- test/plc_gear_partner.sv ----
// plc sequence model: answers the speed strobe with completion after a delay
// assumes the controller's clock and a synchronous active-low reset
`timescale 1ns/1ns
`default_nettype none
module plc_gear_partner (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst_n,
    // handshake
    input  wire logic       speed_strobe,
    input  wire logic [7:0] delay,
    output var  logic       completion
);
    logic [7:0] wait_q;

    // completion is held until the strobe falls, so a slow controller cannot miss it
    always @(posedge clk) begin
        if (!rst_n) begin
            wait_q <= 8'h00;
            completion <= 1'b0;
        end else if (!speed_strobe) begin
            wait_q <= 8'h00;
            completion <= 1'b0;
        end else if (wait_q >= delay) begin
            completion <= 1'b1;
        end else begin
            wait_q <= wait_q + 8'h01;
        end
    end
endmodule
`default_nettype wire

// ---- test/test_spindle_gear_ctrl.sv ----
// self-checking bench for the spindle speed and gear controller
// assumes the register map header and a plc partner model beside the design
`timescale 1ns/1ns
`default_nettype none
`include "spindle_gear_regs.vh"
module test_spindle_gear_ctrl;
    logic        core_clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [5:0]  adr = 6'h00;
    logic        rd = 1'b0;
    logic        wr = 1'b0;
    logic [31:0] wdat = 32'h0;
    logic        sel1 = 1'b0;
    logic        sel2 = 1'b0;
    logic [1:0]  gc1 = 2'h0;
    logic [1:0]  gc2 = 2'h0;
    logic        src1 = 1'b0;
    logic        src2 = 1'b0;
    logic [11:0] pcode1 = 12'h000;
    logic [11:0] pcode2 = 12'h000;
    logic [7:0]  plc_delay = 8'h01;
    logic        strobe_d = 1'b0;
    wire  [31:0] rdat;
    wire  [11:0] code1, code2, volt1, volt2;
    wire  [15:0] cmd_bin;
    wire  [3:0]  flags;
    wire         waitreq, plc_completion, strobe, done;
    int          n_fail = 0;
    int          total_checks = 0;
    int          n_rise = 0;

    always #4 core_clk = ~core_clk;

    spindle_gear_ctrl uut (
        .CORE_CLK(core_clk), .RST_N(rst_n), .AVS_ADDRESS(adr), .AVS_READ(rd), .AVS_WRITE(wr),
        .AVS_WRITEDATA(wdat), .AVS_READDATA(rdat), .AVS_WAITREQUEST(waitreq),
        .FIRST_SPINDLE_SELECT(sel1), .SECOND_SPINDLE_SELECT(sel2),
        .GEAR_CODE_BIT_LOW(gc1[0]), .GEAR_CODE_BIT_HIGH(gc1[1]),
        .SECOND_GEAR_CODE_BIT_LOW(gc2[0]), .SECOND_GEAR_CODE_BIT_HIGH(gc2[1]),
        .PLC_SPEED_SOURCE_FIRST(src1), .PLC_SPEED_SOURCE_SECOND(src2), .PLC_SPEED_CODE_INPUT(pcode1),
        .PLC_SPEED_CODE_INPUT_SECOND(pcode2), .PLC_COMPLETION(plc_completion), .COMPUTED_SPEED_CODE_OUTPUT(code1),
        .COMPUTED_SPEED_CODE_OUTPUT_SECOND(code2), .SPEED_COMMAND_BINARY(cmd_bin),
        .AUTO_GEAR_ONE_FLAG(flags[0]), .AUTO_GEAR_TWO_FLAG(flags[1]), .AUTO_GEAR_THREE_FLAG(flags[2]),
        .AUTO_GEAR_FOUR_FLAG(flags[3]), .SPEED_STROBE(strobe), .ANALOG_SPEED_VOLTAGE(volt1),
        .ANALOG_SPEED_VOLTAGE_SECOND(volt2), .BLOCK_DONE(done)
    );

    plc_gear_partner plc (.clk(core_clk), .rst_n(rst_n), .speed_strobe(strobe), .delay(plc_delay), .completion(plc_completion));

    always @(posedge core_clk) begin
        strobe_d <= strobe;
        if (strobe && !strobe_d) n_rise <= n_rise + 1;
    end

    // ****************************************
    // checking and bus tasks
    // ****************************************
    task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic test_done;
        if (n_fail == 0 && total_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d, output logic [31:0] q);
        int k = 0;
        @(posedge core_clk);
        adr <= a;
        wdat <= d;
        wr <= w;
        rd <= !w;
        do begin
            @(posedge core_clk);
            k++;
        end while (waitreq !== 1'b0 && k < 50);
        q = rdat;
        if (waitreq !== 1'b0) begin
            n_fail++;
            test_done();
        end
        wr <= 1'b0;
        rd <= 1'b0;
    endtask

    task automatic wreg(input logic [5:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask

    task automatic rchk(input string what, input logic [5:0] a, input logic [31:0] exp);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        chk(what, q, exp);
    endtask

    // a speed command runs until the one-cycle done pulse
    task automatic cmd(input logic [15:0] s);
        int k = 0;
        wreg(`A_CMD, {16'h0, s});
        while (done !== 1'b1 && k < 2000) begin
            @(posedge core_clk);
            k++;
        end
        if (done !== 1'b1) begin
            n_fail++;
            test_done();
        end
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_regs;
        rchk("gear max reset", `A_GMAX1, 32'h270F);
        rchk("motor max reset", `A_VMAX, 32'hFFF);
        rchk("motor min reset", `A_VMIN, 32'h0);
        rchk("strobe delay reset", `A_TMF, 32'h10);
        wreg(6'h3F, 32'h1234);
        rchk("unmapped", 6'h3F, 32'h0);
        wreg(`A_TMF, 32'h0);
        wreg(`A_OFS_HI, 32'h0);
        wreg(`A_OFS_LO, 32'h0);
    endtask

    task automatic t_ext_gears;
        logic [11:0] exp [4] = '{12'hCCC, 12'h666, 12'h333, 12'h222};
        logic [15:0] gm [4] = '{16'h03E8, 16'h07D0, 16'h0FA0, 16'h1770};
        for (int g = 0; g < 4; g++)
            wreg(`A_GMAX1 + g[5:0], {16'h0, gm[g]});
        sel1 <= 1'b1;
        for (int g = 0; g < 4; g++) begin
            gc1 <= g[1:0];
            cmd(16'h0320);
            chk("code one", {20'h0, code1}, {20'h0, exp[g]});
            chk("voltage one", {20'h0, volt1}, {20'h0, exp[g]});
            chk("flags", {28'h0, flags}, 32'h0);
        end
        chk("command binary", {16'h0, cmd_bin}, 32'h320);
        chk("strobe count", n_rise, 32'h0);
    endtask

    task automatic t_select;
        sel1 <= 1'b0;
        sel2 <= 1'b1;
        gc2 <= 2'h3;
        cmd(16'h270F);
        chk("code two", {20'h0, code2}, 32'hFFF);
        chk("code one kept", {20'h0, code1}, 32'h222);
        wreg(`A_OFS_HI, 32'h270F);
        sel1 <= 1'b1;
        sel2 <= 1'b0;
        src1 <= 1'b1;
        pcode1 <= 12'h123;
        cmd(16'h0320);
        chk("plc code one", {20'h0, code1}, 32'h123);
        chk("offset voltage", {20'h0, volt1}, 32'h246);
        chk("code two untouched", {20'h0, code2}, 32'hFFF);
        sel1 <= 1'b0;
        sel2 <= 1'b1;
        src1 <= 1'b0;
        src2 <= 1'b1;
        pcode2 <= 12'h456;
        cmd(16'h0320);
        chk("plc code two", {20'h0, code2}, 32'h456);
        chk("code one held", {20'h0, code1}, 32'h222);
        wreg(`A_OFS_HI, 32'h0);
        src1 <= 1'b0;
        src2 <= 1'b0;
        sel2 <= 1'b0;
        sel1 <= 1'b1;
        cmd(16'h0000);
        chk("zero one", {20'h0, code1}, 32'h0);
        chk("zero two", {20'h0, code2}, 32'h0);
        chk("zero voltage two", {20'h0, volt2}, 32'h0);
    endtask

    task automatic auto_step(input logic [15:0] s, input logic [3:0] fl, input logic [11:0] c, input int rises);
        int r0;
        r0 = n_rise;
        cmd(s);
        chk("auto flags", {28'h0, flags}, {28'h0, fl});
        chk("auto code", {20'h0, code1}, {20'h0, c});
        chk("strobe count", n_rise - r0, rises);
    endtask

    task automatic t_auto;
        wreg(`A_CTRL, 32'h1);
        auto_step(16'h0320, 4'h1, 12'hCCC, 0);
        auto_step(16'h0258, 4'h1, 12'h999, 0);
        plc_delay <= 8'h14;
        auto_step(16'h0640, 4'h2, 12'hCCC, 1);
        plc_delay <= 8'h01;
        auto_step(16'h12C0, 4'h8, 12'hCCC, 1);
        wreg(`A_SW1, 32'hCCB);
        wreg(`A_SW1 + 6'h01, 32'hFFF);
        wreg(`A_SW1 + 6'h02, 32'hFFF);
        wreg(`A_CTRL, 32'h3);
        auto_step(16'h0320, 4'h2, 12'h666, 1);
        wreg(`A_CTRL, 32'h1);
        wreg(`A_VMAX, 32'hBB8);
        auto_step(16'h0320, 4'h2, 12'h666, 0);
        wreg(`A_VMIN, 32'h700);
        auto_step(16'h0320, 4'h2, 12'h700, 0);
        wreg(`A_CTRL, 32'h5);
        gc1 <= 2'h0;
        cmd(16'h0320);
        chk("dual flags", {28'h0, flags}, 32'h0);
        chk("dual code", {20'h0, code1}, 32'hCCC);
    endtask

    initial begin
        repeat (16) @(posedge core_clk);
        rst_n <= 1'b1;
        t_regs();
        t_ext_gears();
        t_select();
        t_auto();
        test_done();
    end
endmodule

bind spindle_gear_ctrl spindle_gear_checker chk_i (
    .CORE_CLK(CORE_CLK), .RST_N(RST_N), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
    .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST), .PLC_COMPLETION(PLC_COMPLETION),
    .SPEED_STROBE(SPEED_STROBE), .AUTO_GEAR_ONE_FLAG(AUTO_GEAR_ONE_FLAG), .AUTO_GEAR_TWO_FLAG(AUTO_GEAR_TWO_FLAG),
    .AUTO_GEAR_THREE_FLAG(AUTO_GEAR_THREE_FLAG), .AUTO_GEAR_FOUR_FLAG(AUTO_GEAR_FOUR_FLAG), .BLOCK_DONE(BLOCK_DONE)
);
`default_nettype wire
